// ==== design/vgpc_regs.sv ====
// Behaviour
// - Volume code maps -100 dB to +24 dB in half-dB steps.
// - 0xff is +24 dB, 0x07 is -100 dB, 0xcf is 0 dB; resets 0xcf.
// - Volume code below 0x07 mutes like the mute bit but skips the ramp: applied code jumps to it and goes idle.
// - 3-bit code locks PWM rate to frame clock; double speed halves ratio.
// - PWM rate field resets to 101: 16x single, 8x double speed.
// - Gain code 00..11 gives 19.2, 20.7, 23.5, 26.3 dBV; resets 01.
// - Speed select: 0 single speed (reset), 1 double; picks ratio column.
// - Mute ramps volume down then idles; clearing leaves mute; resets clear.
`timescale 1ns/1ps
`default_nettype none
module vgpc_regs
    import vgpc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       clk_en_i,
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    output logic            rd_valid_o,
    input  wire logic       speed_select_i,
    input  wire logic       mute_i,
    output logic      [7:0] volume_code_o,
    output logic signed [8:0] level_half_db_o,
    output logic            mute_active_o,
    output logic            idle_audio_o,
    output logic      [7:0] applied_code_o,
    output logic      [2:0] pwm_rate_o,
    output logic      [4:0] pwm_ratio_o,
    output logic      [1:0] analog_gain_o,
    output logic      [8:0] gain_dbv_x10_o
);
    logic [7:0]       vol_r;
    logic [7:0]       ana_r;
    logic [7:0]       ramp_r;
    logic [7:0]       rdata_r;
    logic             rd_valid_r;
    logic [1:0]       step_cnt_r;
    logic [4:0]       ratio_r;
    logic [4:0]       ratio_nxt;
    logic             mute_req;
    vgpc_mute_state_t mstate_r;

    function automatic logic [8:0] gain_dbv(input logic [1:0] code);
        case (code)
            2'h0:    gain_dbv = VGPC_GAIN_DBV_00;
            2'h1:    gain_dbv = VGPC_GAIN_DBV_01;
            2'h2:    gain_dbv = VGPC_GAIN_DBV_10;
            default: gain_dbv = VGPC_GAIN_DBV_11;
        endcase
    endfunction

    // Register writes; reserved bits stored as written
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            vol_r <= VGPC_VOL_RST;
            ana_r <= VGPC_ANA_RST;
        end else if (clk_en_i && wr_en_i) begin
            if (addr_i == VGPC_VOL_OFFS)
                vol_r <= wdata_i;
            if (addr_i == VGPC_ANA_OFFS)
                ana_r <= wdata_i;
        end
    end

    // Registered read data; unmapped offsets read zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r    <= 8'h00;
            rd_valid_r <= 1'b0;
        end else if (clk_en_i) begin
            rd_valid_r <= rd_en_i;
            if (rd_en_i) begin
                if (addr_i == VGPC_VOL_OFFS)
                    rdata_r <= vol_r;
                else if (addr_i == VGPC_ANA_OFFS)
                    rdata_r <= ana_r;
                else
                    rdata_r <= 8'h00;
            end
        end
    end

    assign rdata_o    = rdata_r;
    assign rd_valid_o = rd_valid_r;

    // Low codes are folded into the same mute path as the mute bit
    assign mute_req = mute_i || (vol_r < VGPC_VOL_MIN_CODE);

    // Ramp walks the applied code one half-dB step per few cycles to avoid pops
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mstate_r   <= VGPC_PLAY;
            ramp_r     <= VGPC_VOL_RST;
            step_cnt_r <= 2'h0;
        end else if (clk_en_i) begin
            step_cnt_r <= step_cnt_r + 2'h1;
            case (mstate_r)
                VGPC_PLAY: begin
                    ramp_r <= vol_r;
                    if (mute_req)
                        mstate_r <= VGPC_RAMP;
                end
                VGPC_RAMP: begin
                    if (!mute_req) begin
                        mstate_r <= VGPC_PLAY;
                    end else if (ramp_r <= VGPC_VOL_MIN_CODE) begin
                        mstate_r <= VGPC_IDLE;
                    end else if (step_cnt_r == 2'(VGPC_RAMP_STEP_CYC - 1)) begin
                        ramp_r <= ramp_r - 8'h01;
                    end
                end
                VGPC_IDLE: begin
                    if (!mute_req)
                        mstate_r <= VGPC_PLAY;
                end
                default: mstate_r <= VGPC_PLAY;
            endcase
        end
    end

    assign mute_active_o  = (mstate_r != VGPC_PLAY);
    assign idle_audio_o   = (mstate_r == VGPC_IDLE);
    assign applied_code_o = ramp_r;
    assign volume_code_o  = vol_r;
    // Half-dB steps about the 0 dB code, valid from 0x07 up to 0xff
    assign level_half_db_o = $signed({1'b0, vol_r}) - $signed(VGPC_ZERO_DB_CODE);

    assign pwm_rate_o     = ana_r[VGPC_ANA_RATE_POS +: 3];
    assign analog_gain_o  = ana_r[VGPC_ANA_GAIN_POS +: 2];
    assign gain_dbv_x10_o = gain_dbv(analog_gain_o);

    vgpc_pwm_ratio u_ratio (
        .rate_code_i    (pwm_rate_o),
        .speed_select_i (speed_select_i),
        .ratio_o        (ratio_nxt)
    );

    // Ratio registered so the PWM lock sees a glitch-free value
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i)
            ratio_r <= VGPC_RATIO_RST;
        else if (clk_en_i)
            ratio_r <= ratio_nxt;
    end
    assign pwm_ratio_o = ratio_r;

    a_vol_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        (clk_en_i && wr_en_i && addr_i == VGPC_VOL_OFFS) |=> (vol_r == $past(wdata_i)))
        else $error("volume register lost write");
    a_low_code_mutes: assert property (@(posedge clk_i) disable iff (rst_i)
        (clk_en_i && vol_r < VGPC_VOL_MIN_CODE && mstate_r == VGPC_PLAY) |=> mute_active_o)
        else $error("low volume code did not mute");
    a_zero_db_code: assert property (@(posedge clk_i) disable iff (rst_i)
        (vol_r == VGPC_ZERO_DB_CODE[7:0]) |-> (level_half_db_o == 9'sd0))
        else $error("0 dB code mismatch");
    a_level_max: assert property (@(posedge clk_i) disable iff (rst_i)
        (vol_r == VGPC_VOL_MAX_CODE) |-> (level_half_db_o == 9'sd48))
        else $error("top code not +24 dB");
    a_ratio_double: assert property (@(posedge clk_i) disable iff (rst_i)
        (clk_en_i && speed_select_i && pwm_rate_o == VGPC_RATE_RST) |=> (pwm_ratio_o == 5'd8))
        else $error("double speed ratio wrong");
    a_ratio_single: assert property (@(posedge clk_i) disable iff (rst_i)
        (clk_en_i && !speed_select_i && pwm_rate_o == 3'h7) |=> (pwm_ratio_o == 5'd24))
        else $error("single speed ratio wrong");
    a_gain_map: assert property (@(posedge clk_i) disable iff (rst_i)
        (analog_gain_o == VGPC_GAIN_RST) |-> (gain_dbv_x10_o == 9'd207))
        else $error("gain code 01 not 20.7 dBV");
    a_unmute_exit: assert property (@(posedge clk_i) disable iff (rst_i)
        (clk_en_i && idle_audio_o && !mute_req) |=> !mute_active_o)
        else $error("mute not left");
    a_ana_reset: assert property (@(posedge clk_i)
        $fell(rst_i) |-> (pwm_rate_o == VGPC_RATE_RST
            && ana_r[VGPC_ANA_RSV_LO_POS +: 2] == VGPC_RSV_LO_VAL && !ana_r[VGPC_ANA_RSV_HI_POS]))
        else $error("analog reset value wrong");
    a_vol_reset: assert property (@(posedge clk_i)
        $fell(rst_i)
        |-> (vol_r == VGPC_VOL_RST && !mute_active_o))
        else $error("volume reset value wrong");
    a_level_min: assert property (@(posedge clk_i) disable iff (rst_i)
        (vol_r == VGPC_VOL_MIN_CODE)
        |-> (level_half_db_o == 9'h138))
        else $error("bottom code not -100 dB");
    a_ratio_single_rst: assert property (@(posedge clk_i) disable iff (rst_i)
        (clk_en_i && !speed_select_i && pwm_rate_o == VGPC_RATE_RST)
        |=> (pwm_ratio_o == 5'h10))
        else $error("single speed default ratio wrong");

    // Mute path: the ramp must be gradual and must end in idle audio
    a_mute_bit_enters: assert property (@(posedge clk_i) disable iff (rst_i)
        (clk_en_i && mute_i && mstate_r == VGPC_PLAY)
        |=> mute_active_o)
        else $error("mute bit did not start the ramp");
    a_ramp_one_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (clk_en_i && mstate_r == VGPC_RAMP)
        |=> (ramp_r == $past(ramp_r) || ramp_r == $past(ramp_r) - 8'h01))
        else $error("ramp moved more than one step");
    a_ramp_ends_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        (clk_en_i && mstate_r == VGPC_RAMP && mute_req && ramp_r <= VGPC_VOL_MIN_CODE)
        |=> idle_audio_o)
        else $error("ramp did not end in idle audio");
    a_idle_floor: assert property (@(posedge clk_i) disable iff (rst_i)
        idle_audio_o
        |-> (applied_code_o <= VGPC_VOL_MIN_CODE))
        else $error("idle audio above the bottom code");

    // Bus answer: one enabled cycle later, unmapped offsets read zero
    a_rd_valid_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        (clk_en_i && rd_en_i)
        |=> rd_valid_o)
        else $error("read not answered");
    a_ana_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        (clk_en_i && rd_en_i && addr_i == VGPC_ANA_OFFS)
        |=> (rdata_o == $past(ana_r)))
        else $error("analog register read back wrong");
    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (clk_en_i && rd_en_i && addr_i != VGPC_VOL_OFFS && addr_i != VGPC_ANA_OFFS)
        |=> (rdata_o == 8'h00))
        else $error("unmapped offset read not zero");
    a_enable_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
        !clk_en_i
        |=> ($stable(vol_r) && $stable(ana_r) && $stable(rdata_o) && $stable(mstate_r)))
        else $error("state moved while enable low");
endmodule
`default_nettype wire

// ==== include/vgpc_pkg.sv ====
package vgpc_pkg;
    localparam logic [7:0] VGPC_VOL_OFFS       = 8'h04;
    localparam logic [7:0] VGPC_ANA_OFFS       = 8'h06;
    localparam logic [7:0] VGPC_VOL_RST        = 8'hcf;
    localparam logic [7:0] VGPC_VOL_MIN_CODE   = 8'h07;
    localparam logic [7:0] VGPC_VOL_MAX_CODE   = 8'hff;
    localparam logic [7:0] VGPC_ANA_RST        = 8'h55;
    localparam int         VGPC_ANA_RSV_HI_POS = 7;
    localparam int         VGPC_ANA_RATE_POS   = 4;
    localparam int         VGPC_ANA_GAIN_POS   = 2;
    localparam int         VGPC_ANA_RSV_LO_POS = 0;
    localparam logic [2:0] VGPC_RATE_RST       = 3'h5;
    localparam logic [1:0] VGPC_GAIN_RST       = 2'h1;
    localparam logic [1:0] VGPC_RSV_LO_VAL     = 2'h1;
    localparam logic [4:0] VGPC_RATIO_RST      = 5'h10;
    // Level in half-dB units: code 0x07 is -200, 0xcf is 0, 0xff is +48
    localparam logic [8:0] VGPC_ZERO_DB_CODE   = 9'h0cf;
    // Output level at full scale, in 0.1 dBV units, per gain code
    localparam logic [8:0] VGPC_GAIN_DBV_00    = 9'h0c0;
    localparam logic [8:0] VGPC_GAIN_DBV_01    = 9'h0cf;
    localparam logic [8:0] VGPC_GAIN_DBV_10    = 9'h0eb;
    localparam logic [8:0] VGPC_GAIN_DBV_11    = 9'h107;
    localparam int         VGPC_RAMP_STEP_CYC  = 4;

    typedef enum logic [1:0] {
        VGPC_PLAY,
        VGPC_RAMP,
        VGPC_IDLE
    } vgpc_mute_state_t;
endpackage

// ==== design/vgpc_pwm_ratio.sv ====
`timescale 1ns/1ps
`default_nettype none
module vgpc_pwm_ratio
    import vgpc_pkg::*;
(
    input  wire logic [2:0] rate_code_i,
    input  wire logic       speed_select_i,
    output logic      [4:0] ratio_o
);
    logic [4:0] single_ratio;

    always_comb begin
        case (rate_code_i)
            3'h0:    single_ratio = 5'h06;
            3'h1:    single_ratio = 5'h08;
            3'h2:    single_ratio = 5'h0a;
            3'h3:    single_ratio = 5'h0c;
            3'h4:    single_ratio = 5'h0e;
            3'h5:    single_ratio = 5'h10;
            3'h6:    single_ratio = 5'h14;
            default: single_ratio = 5'h18;
        endcase
    end

    // Double speed halves every ratio; all single ratios are even
    assign ratio_o = speed_select_i ? {1'b0, single_ratio[4:1]} : single_ratio;
endmodule
`default_nettype wire

// ==== tb/vgpc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module vgpc_host (
    input  wire logic       clk_i,
    output logic            wr_en_o,
    output logic            rd_en_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o  = 8'h00;
        wdata_o = 8'h00;
    end
    // Strobe for one edge; released data is inverted so nothing stale looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_en_o <= 1'b1;
        addr_o  <= a;
        wdata_o <= d;
        @(posedge clk_i);
        wr_en_o <= 1'b0;
        wdata_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        rd_en_o <= 1'b1;
        addr_o  <= a;
        @(posedge clk_i);
        rd_en_o <= 1'b0;
    endtask
    // Reserved top bit written 0, reserved low pair written 01
    task automatic ana(input logic [2:0] rate, input logic [1:0] gain);
        wr(8'h06, {1'b0, rate, gain, 2'b01});
    endtask
endmodule
`default_nettype wire

// ==== tb/volume_gain_pwm_config_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module volume_gain_pwm_config_tb
    import vgpc_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, clk_en_i = 1'b1, spd = 1'b0, mute_i = 1'b0;
    logic wr_en, rd_en, rd_valid_o, mute_active_o, idle_audio_o;
    logic [7:0] addr, wdata, rdata_o, volume_code_o, applied_code_o, c;
    logic signed [8:0] level_half_db_o;
    logic [2:0] pwm_rate_o;
    logic [4:0] pwm_ratio_o;
    logic [1:0] analog_gain_o;
    logic [8:0] gain_dbv_x10_o;
    logic [31:0] lfsr = 32'hf3b7b0be;
    logic [7:0] expq[$];
    int mismatches = 0, compares = 0;
    logic [4:0] rt[8] = '{5'd6, 5'd8, 5'd10, 5'd12, 5'd14, 5'd16, 5'd20, 5'd24};
    logic [8:0] gd[4] = '{VGPC_GAIN_DBV_00, VGPC_GAIN_DBV_01, VGPC_GAIN_DBV_10, VGPC_GAIN_DBV_11};
    always #12.5 clk_i = ~clk_i;
    vgpc_host i_host (.clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
                      .wdata_o(wdata));
    vgpc_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .wr_en_i(wr_en),
        .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata_o),
        .rd_valid_o(rd_valid_o), .speed_select_i(spd), .mute_i(mute_i),
        .volume_code_o(volume_code_o), .level_half_db_o(level_half_db_o),
        .mute_active_o(mute_active_o), .idle_audio_o(idle_audio_o),
        .applied_code_o(applied_code_o), .pwm_rate_o(pwm_rate_o), .pwm_ratio_o(pwm_ratio_o),
        .analog_gain_o(analog_gain_o), .gain_dbv_x10_o(gain_dbv_x10_o));
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        i_host.rd(a);
    endtask
    task automatic end_sim();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        // Valid freezes with the enable, so it counts on enabled edges only
        if (rd_valid_o === 1'b1 && clk_en_i === 1'b1) chk(rdata_o, expq.pop_front());
    end
    initial begin
        #(25ns * 20000);
        mismatches++;
        end_sim();
    end
    task automatic rst_check();
        rd(VGPC_VOL_OFFS, 8'hcf);
        rd(VGPC_ANA_OFFS, 8'h55);
        repeat (3) @(negedge clk_i);
        chk(pwm_ratio_o, spd ? 5'h08 : 5'h10);
        chk(gain_dbv_x10_o, VGPC_GAIN_DBV_01);
        chk(mute_active_o, 1'b0);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rst_check();
        for (int s = 0; s < 2; s++) begin
            for (int r = 0; r < 8; r++) begin
                @(posedge clk_i);
                spd <= s[0];
                i_host.ana(r[2:0], r[1:0]);
                repeat (4) @(negedge clk_i);
                chk(pwm_rate_o, r[2:0]);
                chk(pwm_ratio_o, rt[r] >> s);
                chk(analog_gain_o, r[1:0]);
                chk(gain_dbv_x10_o, gd[r[1:0]]);
                rd(VGPC_ANA_OFFS, {1'b0, r[2:0], r[1:0], 2'b01});
            end
        end
        for (int i = 0; i < 10; i++) begin
            lfsr = lfsr_next(lfsr);
            c = (i < 3) ? ((i == 0) ? 8'hff : (i == 1) ? 8'h07 : 8'hcf) : (lfsr[7:0] | 8'h08);
            i_host.wr(VGPC_VOL_OFFS, c);
            repeat (3) @(negedge clk_i);
            chk(level_half_db_o, {1'b0, c} - 9'h0cf);
            chk(volume_code_o, c);
            chk(mute_active_o, 1'b0);
            rd(VGPC_VOL_OFFS, c);
        end
        i_host.wr(8'h05, 8'h5a);
        rd(8'h05, 8'h00);
        rd(VGPC_VOL_OFFS, c);
        clk_en_i <= 1'b0;
        i_host.wr(VGPC_VOL_OFFS, 8'h33);
        clk_en_i <= 1'b1;
        rd(VGPC_VOL_OFFS, c);
        i_host.wr(VGPC_VOL_OFFS, 8'h06);
        repeat (4) @(negedge clk_i);
        chk(mute_active_o, 1'b1);
        chk(idle_audio_o, 1'b1);
        i_host.wr(VGPC_VOL_OFFS, 8'h10);
        repeat (3) @(negedge clk_i);
        chk(mute_active_o, 1'b0);
        @(posedge clk_i);
        mute_i <= 1'b1;
        repeat (3) @(negedge clk_i);
        chk(mute_active_o, 1'b1);
        chk(idle_audio_o, 1'b0);
        repeat (1000) @(negedge clk_i);
        chk(mute_active_o, 1'b1);
        chk(idle_audio_o, 1'b1);
        chk(applied_code_o, VGPC_VOL_MIN_CODE);
        @(posedge clk_i);
        mute_i <= 1'b0;
        repeat (3) @(negedge clk_i);
        chk(mute_active_o, 1'b0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rst_check();
        repeat (4) @(posedge clk_i);
        end_sim();
    end
endmodule
`default_nettype wire
